/* File: core/cssu_pkg.sv */
// Package for the clock source select and startup block.
// Assumes a single 100 MHz system clock; oscillator ticks arrive as pins.
package cssu_pkg;

	// ------------------------------------------------------------------
	// Register offsets (byte addresses on the plain register port)
	// ------------------------------------------------------------------
	localparam logic [7:0] CSSU_OFS_CTRL   = 8'h00; // Control register
	localparam logic [7:0] CSSU_OFS_STATUS = 8'h04; // Fail status (W1C)
	localparam logic [7:0] CSSU_OFS_MASK   = 8'h08; // Fail interrupt mask
	localparam logic [7:0] CSSU_OFS_START  = 8'h0C; // Startup state view

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int CSSU_B_MODE_LO  = 0; // Source mode field, low bit
	localparam int CSSU_B_MODE_HI  = 1; // Source mode field, high bit
	localparam int CSSU_B_SLOW_DIS = 2; // Slow oscillator disable
	localparam int CSSU_B_MON_EN   = 3; // Clock monitoring enable
	localparam int CSSU_B_CORE_SEL = 4; // Core select
	localparam int CSSU_B_EXT_SEL  = 5; // External input select
	localparam int CSSU_B_FAIL     = 0; // Fail flag / fail enable

	// ------------------------------------------------------------------
	// Reset values and encodings
	// ------------------------------------------------------------------
	localparam logic [7:0] CSSU_CTRL_RST = 8'h00;
	localparam logic [7:0] CSSU_MASK_RST = 8'h00;
	localparam logic [7:0] CSSU_ZERO8    = 8'h00;
	localparam logic [1:0] CSSU_MODE_SLOW = 2'b10; // Slow RC oscillator
	localparam logic [1:0] CSSU_MODE_EXT  = 2'b11; // External clock
	localparam logic [1:0] CSSU_SUT_FAST  = 2'b01; // Fast rising power
	localparam logic [1:0] CSSU_SUT_SLOW  = 2'b10; // Slow rising power

	// ------------------------------------------------------------------
	// Timing counts
	// ------------------------------------------------------------------
	localparam int CSSU_TOUT_SHORT = 512;  // Slow osc cycles, short
	localparam int CSSU_TOUT_LONG  = 8192; // Slow osc cycles, long
	localparam int CSSU_POR_CLKS   = 14;   // Prescaler clocks after reset
	localparam int CSSU_WAKE_CLKS  = 6;    // Prescaler clocks on wake
	localparam int CSSU_CNT_W      = 14;   // Counter width

	// Prescaler input selection
	typedef enum logic [1:0] {
		CSSU_SRC_FAST,
		CSSU_SRC_SLOW,
		CSSU_SRC_EXT
	} cssu_src_e;

	// Fuse set that reaches the block
	typedef struct packed {
		logic       wdog_force;  // Watchdog oscillator forced on
		logic       fast_freq;   // Fast oscillator frequency fuse
		logic [1:0] startup_sel; // Startup select fuse
		logic       div8;        // Divide-by-eight fuse
	} cssu_fuse_s;

	// Plain register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cssu_bus_s;

endpackage : cssu_pkg

/* File: core/cssu_top.sv */
// Clock source select, failure flag and startup reset sequencing.
// Assumes oscillator and prescaler activity arrive as asynchronous tick
// levels, sampled on clk_sys; clock muxing itself happens in analog.
`timescale 1ns/1ns
`default_nettype none

module cssu_top #(
	parameter int TOUT_SHORT = cssu_pkg::CSSU_TOUT_SHORT,
	parameter int TOUT_LONG  = cssu_pkg::CSSU_TOUT_LONG
) (
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	// Register port
	input  wire cssu_pkg::cssu_bus_s  bus_req,
	output logic [7:0]                bus_rdata,
	// Fuses, oscillator ticks and events
	input  wire cssu_pkg::cssu_fuse_s fuse,
	input  wire logic                 slow_osc_tick,
	input  wire logic                 presc_out_tick,
	input  wire logic                 ext_loss,
	input  wire logic                 other_resets_n,
	input  wire logic                 wake_req,
	input  wire logic                 vector_ack,
	input  wire logic                 global_irq_en,
	// Clock control outputs
	output cssu_pkg::cssu_src_e       presc_input_sel,
	output logic                      ext_input_sel,
	output logic                      slow_osc_run,
	output logic                      divide_by_eight,
	output logic                      core_clk_en,
	output logic                      watchdog_clk_en,
	output logic                      internal_reset_n,
	output logic                      fail_irq
);
	import cssu_pkg::*;

	// ------------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------------
	initial begin
		if (TOUT_SHORT < 1 || TOUT_LONG < TOUT_SHORT ||
		    TOUT_LONG >= (1 << CSSU_CNT_W))
			$error("cssu_top: time-out counts out of range");
	end

	// Sized limits for the counter
	localparam logic [CSSU_CNT_W-1:0] LIM_SHORT = CSSU_CNT_W'(TOUT_SHORT);
	localparam logic [CSSU_CNT_W-1:0] LIM_LONG  = CSSU_CNT_W'(TOUT_LONG);
	localparam logic [CSSU_CNT_W-1:0] LIM_POR   = CSSU_CNT_W'(CSSU_POR_CLKS);
	localparam logic [CSSU_CNT_W-1:0] LIM_WAKE  = CSSU_CNT_W'(CSSU_WAKE_CLKS);
	localparam logic [CSSU_CNT_W-1:0] CNT_ONE   = CSSU_CNT_W'(1);

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [1:0] mode_r;      // Source mode field
	logic       slow_dis_r;  // Slow oscillator disable
	logic       mon_en_r;    // Clock monitoring enable
	logic       core_sel_r;  // Core select
	logic       ext_sel_r;   // External input select
	logic       fail_flag_r; // External clock fail flag
	logic       fail_en_r;   // Fail interrupt enable
	logic [7:0] rdata_r;     // Read data, one cycle after strobe

	// Three-stage synchronisers for off-domain inputs
	logic [2:0] s_slow_r, s_presc_r, s_loss_r, s_rst_r, s_wake_r;
	logic       slow_lvl_r, presc_lvl_r, loss_lvl_r, rst_lvl_r, wake_lvl_r;

	// Startup sequencer
	typedef enum logic [1:0] {ST_TOUT, ST_CLKS, ST_RUN} cssu_st_e;
	cssu_st_e              st_r;
	logic [CSSU_CNT_W-1:0] cnt_r;
	logic [CSSU_CNT_W-1:0] clk_lim_r; // 14 after reset, 6 after wake

	// Write decode helper
	function automatic logic wr_hit(input cssu_bus_s b,
	                                input logic [7:0] ofs);
		wr_hit = b.wr && (b.addr == ofs);
	endfunction : wr_hit

	// ------------------------------------------------------------------
	// Synchronisers: a change counts once stages two and three agree
	// ------------------------------------------------------------------
	// Filtered level updates only on agreement, so a glitch is dropped
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_slow_r    <= 3'h0;
			s_presc_r   <= 3'h0;
			s_loss_r    <= 3'h0;
			s_rst_r     <= 3'h0;
			s_wake_r    <= 3'h0;
			slow_lvl_r  <= 1'b0;
			presc_lvl_r <= 1'b0;
			loss_lvl_r  <= 1'b0;
			rst_lvl_r   <= 1'b0;
			wake_lvl_r  <= 1'b0;
		end else begin
			s_slow_r  <= {s_slow_r[1:0], slow_osc_tick};
			s_presc_r <= {s_presc_r[1:0], presc_out_tick};
			s_loss_r  <= {s_loss_r[1:0], ext_loss};
			s_rst_r   <= {s_rst_r[1:0], other_resets_n};
			s_wake_r  <= {s_wake_r[1:0], wake_req};
			if (s_slow_r[1] == s_slow_r[2])
				slow_lvl_r <= s_slow_r[2];
			if (s_presc_r[1] == s_presc_r[2])
				presc_lvl_r <= s_presc_r[2];
			if (s_loss_r[1] == s_loss_r[2])
				loss_lvl_r <= s_loss_r[2];
			if (s_rst_r[1] == s_rst_r[2])
				rst_lvl_r <= s_rst_r[2];
			if (s_wake_r[1] == s_wake_r[2])
				wake_lvl_r <= s_wake_r[2];
		end
	end

	// Edge of filtered levels
	logic slow_d_r, presc_d_r, wake_d_r;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			slow_d_r  <= 1'b0;
			presc_d_r <= 1'b0;
			wake_d_r  <= 1'b0;
		end else begin
			slow_d_r  <= slow_lvl_r;
			presc_d_r <= presc_lvl_r;
			wake_d_r  <= wake_lvl_r;
		end
	end
	logic slow_edge, presc_edge, wake_edge;
	assign slow_edge  = slow_lvl_r && !slow_d_r;
	assign presc_edge = presc_lvl_r && !presc_d_r;
	assign wake_edge  = wake_lvl_r && !wake_d_r;

	// ------------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------------
	// Failure only forces core select back; mode bits are kept
	logic fail_event;
	assign fail_event = loss_lvl_r && mon_en_r && core_sel_r &&
	                    (mode_r == CSSU_MODE_EXT);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode_r     <= CSSU_CTRL_RST[CSSU_B_MODE_HI:CSSU_B_MODE_LO];
			slow_dis_r <= CSSU_CTRL_RST[CSSU_B_SLOW_DIS];
			mon_en_r   <= CSSU_CTRL_RST[CSSU_B_MON_EN];
			core_sel_r <= CSSU_CTRL_RST[CSSU_B_CORE_SEL];
			ext_sel_r  <= CSSU_CTRL_RST[CSSU_B_EXT_SEL];
		end else begin
			if (wr_hit(bus_req, CSSU_OFS_CTRL)) begin
				mode_r     <= bus_req.wdata[CSSU_B_MODE_HI:CSSU_B_MODE_LO];
				slow_dis_r <= bus_req.wdata[CSSU_B_SLOW_DIS];
				mon_en_r   <= bus_req.wdata[CSSU_B_MON_EN];
				core_sel_r <= bus_req.wdata[CSSU_B_CORE_SEL];
				ext_sel_r  <= bus_req.wdata[CSSU_B_EXT_SEL];
			end
			// Failure wins over a simultaneous write of core select
			if (fail_event)
				core_sel_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Fail flag and mask
	// ------------------------------------------------------------------
	// Set wins over write-one clear and vector clear
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			fail_flag_r <= 1'b0;
		end else if (fail_event) begin
			fail_flag_r <= 1'b1;
		end else if (vector_ack) begin
			fail_flag_r <= 1'b0;
		end else if (wr_hit(bus_req, CSSU_OFS_STATUS) &&
		             bus_req.wdata[CSSU_B_FAIL]) begin
			fail_flag_r <= 1'b0;
		end
	end

	// Mask register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			fail_en_r <= CSSU_MASK_RST[CSSU_B_FAIL];
		else if (wr_hit(bus_req, CSSU_OFS_MASK))
			fail_en_r <= bus_req.wdata[CSSU_B_FAIL];
	end

	// Request to the core's interrupt logic
	assign fail_irq = fail_flag_r && fail_en_r && global_irq_en;

	// ------------------------------------------------------------------
	// Startup sequencer
	// ------------------------------------------------------------------
	// Reserved select codes fall back to the long time-out for safety
	logic [CSSU_CNT_W-1:0] tout_lim;
	assign tout_lim = (fuse.startup_sel == CSSU_SUT_FAST) ? LIM_SHORT
	                                                      : LIM_LONG;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_r      <= ST_TOUT;
			cnt_r     <= '0;
			clk_lim_r <= LIM_POR;
		end else if (!rst_lvl_r) begin
			// Other reset sources still active: restart the sequence
			st_r      <= ST_TOUT;
			cnt_r     <= '0;
			clk_lim_r <= LIM_POR;
		end else begin
			unique case (st_r)
				ST_TOUT: begin
					// Count slow oscillator cycles while holding reset
					if (slow_edge) begin
						if (cnt_r + CNT_ONE >= tout_lim) begin
							st_r  <= ST_CLKS;
							cnt_r <= '0;
						end else begin
							cnt_r <= cnt_r + CNT_ONE;
						end
					end
				end
				ST_CLKS: begin
					// Count prescaler output clocks
					if (presc_edge) begin
						if (cnt_r + CNT_ONE >= clk_lim_r) begin
							st_r  <= ST_RUN;
							cnt_r <= '0;
						end else begin
							cnt_r <= cnt_r + CNT_ONE;
						end
					end
				end
				ST_RUN: begin
					// Wake needs only the short startup, no time-out
					if (wake_edge) begin
						st_r      <= ST_CLKS;
						cnt_r     <= '0;
						clk_lim_r <= LIM_WAKE;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Clock selection outputs, from flip-flops
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			presc_input_sel  <= CSSU_SRC_FAST;
			ext_input_sel    <= 1'b0;
			slow_osc_run     <= 1'b1;
			divide_by_eight  <= 1'b1;
			core_clk_en      <= 1'b0;
			watchdog_clk_en  <= 1'b1;
			internal_reset_n <= 1'b0;
		end else begin
			// Reserved modes or core select zero keep the fast oscillator
			if (!core_sel_r)
				presc_input_sel <= CSSU_SRC_FAST;
			else if (mode_r == CSSU_MODE_SLOW)
				presc_input_sel <= CSSU_SRC_SLOW;
			else if (mode_r == CSSU_MODE_EXT)
				presc_input_sel <= CSSU_SRC_EXT;
			else
				presc_input_sel <= CSSU_SRC_FAST;
			ext_input_sel    <= ext_sel_r;
			// Forcing fuse overrides the disable bit; a programmed
			// fuse reads as zero
			slow_osc_run     <= !slow_dis_r || !fuse.wdog_force;
			watchdog_clk_en  <= !slow_dis_r || !fuse.wdog_force;
			divide_by_eight  <= !fuse.div8;
			// Core, I/O and flash clocks run from the prescaler when out
			core_clk_en      <= (st_r == ST_RUN);
			internal_reset_n <= (st_r == ST_RUN);
		end
	end

	// ------------------------------------------------------------------
	// Read port: data stand the cycle after the strobe only
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_r <= CSSU_ZERO8;
		end else if (bus_req.rd) begin
			unique case (bus_req.addr)
				CSSU_OFS_CTRL:   rdata_r <= {2'b00, ext_sel_r, core_sel_r,
				                             mon_en_r, slow_dis_r, mode_r};
				CSSU_OFS_STATUS: rdata_r <= {7'h00, fail_flag_r};
				CSSU_OFS_MASK:   rdata_r <= {7'h00, fail_en_r};
				CSSU_OFS_START:  rdata_r <= {6'h00, st_r};
				default:         rdata_r <= CSSU_ZERO8;
			endcase
		end else begin
			rdata_r <= CSSU_ZERO8;
		end
	end
	assign bus_rdata = rdata_r;

endmodule : cssu_top

`default_nettype wire

/* File: verif/cssu_props.sv */
// Checker for the clock source select and startup block.
// Assumes it is bound to cssu_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none

module cssu_props
	import cssu_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       resetn,
	// Inputs of the block
	input wire cssu_bus_s  bus_req,
	input wire cssu_fuse_s fuse,
	input wire logic       ext_loss,
	input wire logic       other_resets_n,
	input wire logic       global_irq_en,
	// Outputs of the block
	input wire logic [7:0] bus_rdata,
	input wire cssu_src_e  presc_input_sel,
	input wire logic       slow_osc_run,
	input wire logic       divide_by_eight,
	input wire logic       core_clk_en,
	input wire logic       watchdog_clk_en,
	input wire logic       internal_reset_n,
	input wire logic       fail_irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
		else $error("read data not zero outside read slot");
	a_irq_global: assert property (fail_irq |-> global_irq_en)
		else $error("interrupt raised with global enable low");
	a_slow_forced: assert property (!fuse.wdog_force |-> slow_osc_run)
		else $error("slow oscillator stopped while fuse forces it");
	a_wdog_follow: assert property (watchdog_clk_en == slow_osc_run)
		else $error("watchdog clock does not follow slow oscillator");
	a_div8_fuse: assert property ($past(resetn) |-> divide_by_eight == !fuse.div8)
		else $error("divide by eight differs from fuse");
	a_core_release: assert property ($rose(internal_reset_n) |-> core_clk_en)
		else $error("reset released before startup done");
	a_hold_other: assert property (!other_resets_n [*8] |-> !internal_reset_n)
		else $error("internal reset released while other reset held");
	a_fail_drop: assert property (ext_loss [*8] |-> presc_input_sel != CSSU_SRC_EXT)
		else $error("external clock kept after loss");
endmodule : cssu_props

`default_nettype wire

/* File: verif/cssu_tb_top.sv */
// Self-checking bench for the clock source select and startup block.
// Assumes small time-out counts of 4 and 8 slow oscillator cycles.
`timescale 1ns/1ns
`default_nettype none

module cssu_tb_top;
	import cssu_pkg::*;
	logic clk_sys = 1'b0; // 100 MHz system clock
	logic resetn  = 1'b0;
	cssu_bus_s bus_req = '0;
	cssu_fuse_s fuse = '0;
	logic slow_osc_tick = 1'b0, presc_out_tick = 1'b0, ext_loss = 1'b0;
	logic other_resets_n = 1'b1, wake_req = 1'b0, vector_ack = 1'b0;
	logic global_irq_en = 1'b0;
	logic [7:0] bus_rdata;
	cssu_src_e presc_input_sel;
	logic ext_input_sel, slow_osc_run, divide_by_eight, core_clk_en;
	logic watchdog_clk_en, internal_reset_n, fail_irq;
	logic [7:0] exp_q[$]; // Expected read data, oldest first
	logic rd_d = 1'b0;
	logic [3:0] tick_cnt = 4'h0;
	int mismatches = 0, checks = 0, seed = 32'hd573_48b1;
	logic [31:0] r;

	cssu_top #(.TOUT_SHORT(4), .TOUT_LONG(8)) u_cssu_top (
		.clk_sys, .resetn, .bus_req, .bus_rdata, .fuse, .slow_osc_tick,
		.presc_out_tick, .ext_loss, .other_resets_n, .wake_req,
		.vector_ack, .global_irq_en, .presc_input_sel, .ext_input_sel,
		.slow_osc_run, .divide_by_eight, .core_clk_en, .watchdog_clk_en,
		.internal_reset_n, .fail_irq);

	always #5 clk_sys = ~clk_sys;

	// Slow oscillator every 10 cycles, prescaler output every 4 cycles
	always @(posedge clk_sys) begin
		tick_cnt <= (tick_cnt == 4'h9) ? 4'h0 : tick_cnt + 4'h1;
		if (tick_cnt == 4'h0 || tick_cnt == 4'h5) slow_osc_tick <= ~slow_osc_tick;
		presc_out_tick <= tick_cnt[0] ? ~presc_out_tick : presc_out_tick;
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge clk_sys) begin
		if (rd_d) check("rdata", bus_rdata, exp_q.pop_front());
		rd_d <= bus_req.rd;
	end

	task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic cyc(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc

	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_sys);
		bus_req.addr <= a; bus_req.wdata <= d; bus_req.wr <= 1'b1;
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
	endtask : wr

	task automatic rd(logic [7:0] a, logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clk_sys);
		bus_req.addr <= a; bus_req.rd <= 1'b1;
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
	endtask : rd

	// Startup window: still held at lo cycles, released by lo+50
	task automatic startup(int lo);
		cyc(lo);
		check("irst_lo", {7'h00, internal_reset_n}, 8'h00);
		check("div8", {7'h00, divide_by_eight}, 8'h01);
		cyc(50);
		check("irst_hi", {7'h00, internal_reset_n}, 8'h01);
		check("core_en", {7'h00, core_clk_en}, 8'h01);
		rd(8'h0C, 8'h02);
	endtask : startup

	task automatic do_reset(logic wd, logic [1:0] startup_select_fuse);
		resetn <= 1'b0;
		// Time-out stays enabled: no brown-out circuit is modelled
		fuse.wdog_force <= wd; fuse.startup_sel <= startup_select_fuse;
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		startup(startup_select_fuse == CSSU_SUT_FAST ? 80 : 120);
		$display("test startup done");
	endtask : do_reset

	task automatic fail_run(logic b, logic vec);
		logic [7:0] c;
		c = 8'h0B | {2'h0, b, 5'h00};
		wr(8'h00, c); wr(8'h00, c | 8'h10); wr(8'h08, 8'h01);
		global_irq_en <= 1'b1;
		cyc(2);
		check("ext_sel", {7'h00, ext_input_sel}, {7'h00, b});
		@(posedge clk_sys) ext_loss <= 1'b1;
		cyc(8);
		check("src", {6'h00, presc_input_sel}, {6'h00, CSSU_SRC_FAST});
		check("irq", {7'h00, fail_irq}, 8'h01);
		@(posedge clk_sys) ext_loss <= 1'b0;
		rd(8'h00, c);
		rd(8'h04, 8'h01);
		if (vec) begin
			@(posedge clk_sys) vector_ack <= 1'b1;
			@(posedge clk_sys) vector_ack <= 1'b0;
			rd(8'h04, 8'h00);
		end else begin
			wr(8'h04, 8'h00); rd(8'h04, 8'h01);
			global_irq_en <= 1'b0; cyc(1);
			check("irq_g", {7'h00, fail_irq}, 8'h00);
			@(posedge clk_sys) global_irq_en <= 1'b1;
			wr(8'h08, 8'h00); cyc(1);
			check("irq_m", {7'h00, fail_irq}, 8'h00);
			wr(8'h04, 8'h01); rd(8'h04, 8'h00);
		end
		$display("test fail done");
	endtask : fail_run

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	initial begin
		do_reset(1'b1, CSSU_SUT_SLOW);
		rd(8'h00, 8'h00); rd(8'h04, 8'h00); rd(8'h08, 8'h00); rd(8'h10, 8'h00);
		r = $random(seed);
		wr(8'h00, r[7:0] & 8'hEF); rd(8'h00, r[7:0] & 8'h2F);
		wr(8'h08, r[15:8]); rd(8'h08, {7'h00, r[8]});
		wr(8'h00, 8'h04); cyc(2);
		check("slow_run", {7'h00, slow_osc_run}, 8'h00);
		wr(8'h00, 8'h00); cyc(2);
		check("slow_run", {7'h00, slow_osc_run}, 8'h01);
		for (int m = 0; m < 4; m++) begin
			wr(8'h00, 8'h08 | m[7:0]); wr(8'h00, 8'h18 | m[7:0]); cyc(2);
			check("src", {6'h00, presc_input_sel}, m < 2 ? 8'h00 : m[7:0] - 8'h01);
			wr(8'h00, 8'h08 | m[7:0]); cyc(2);
			check("src", {6'h00, presc_input_sel}, 8'h00);
		end
		$display("test modes done");
		fail_run(1'b1, 1'b0);
		fail_run(1'b0, 1'b1);
		// Let the last read answer before reset clears the read data
		repeat (2) @(posedge clk_sys);
		do_reset(1'b0, CSSU_SUT_FAST);
		wr(8'h00, 8'h04); cyc(2);
		check("slow_run", {7'h00, slow_osc_run}, 8'h01);
		@(posedge clk_sys) wake_req <= 1'b1;
		cyc(10);
		check("wake_lo", {7'h00, internal_reset_n}, 8'h00);
		cyc(40);
		check("wake_hi", {7'h00, internal_reset_n}, 8'h01);
		@(posedge clk_sys) wake_req <= 1'b0;
		other_resets_n <= 1'b0;
		cyc(20);
		check("other", {7'h00, internal_reset_n}, 8'h00);
		@(posedge clk_sys) other_resets_n <= 1'b1;
		startup(80);
		$display("test wake done");
		cyc(3);
		summarize;
	end

	initial begin
		#400000;
		mismatches++;
		summarize;
	end
endmodule : cssu_tb_top

bind cssu_top cssu_props u_cssu_props (
	.clk_sys, .resetn, .bus_req, .fuse, .ext_loss, .other_resets_n,
	.global_irq_en, .bus_rdata, .presc_input_sel, .slow_osc_run,
	.divide_by_eight, .core_clk_en, .watchdog_clk_en, .internal_reset_n,
	.fail_irq);

`default_nettype wire
